// ### rtl/qdt_pkg.sv
// Constants and types shared by the quad down-counter timer block.
package qdt_pkg;
   // ==========================================================
   // Sizes
   localparam int unsigned QDT_NUM = 4;
   localparam int unsigned QDT_W = 32;
   localparam int unsigned QDT_PRE_W = 8;
   // ==========================================================
   // Values
   localparam logic [QDT_W-1:0] QDT_ALL_ONES = 32'hffffffff;
   localparam logic [QDT_W-1:0] QDT_ZERO = 32'h00000000;
   localparam logic [QDT_W-1:0] QDT_ONE = 32'h00000001;
   localparam logic [QDT_PRE_W-1:0] QDT_PRE_RST = 8'h00;
   localparam logic [QDT_PRE_W-1:0] QDT_PRE_ONE = 8'h01;
   localparam logic [3:0] QDT_DIV16_MASK = 4'hf;
   localparam logic [QDT_PRE_W-1:0] QDT_DIV256_MASK = 8'hff;
   // ==========================================================
   // Prescaler selection
   typedef enum logic [1:0] {
      QDT_DIV1 = 2'h0,
      QDT_DIV16 = 2'h1,
      QDT_DIV256 = 2'h3
   } qdt_div_t;
endpackage

// ### rtl/qdt_timer.sv
// One 32-bit down-counting timer channel with prescaler and sticky interrupt.
module qdt_timer
   import qdt_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Control
   input wire logic enable,
   input wire logic periodic,
   input wire qdt_pkg::qdt_div_t div_sel,
   input wire logic load_wr,
   input wire logic [qdt_pkg::QDT_W-1:0] load_data,
   input wire logic irq_clr,
   // Status
   output logic [qdt_pkg::QDT_W-1:0] count,
   output logic [qdt_pkg::QDT_W-1:0] load_val,
   output logic irq
);
   typedef struct packed {
      logic [QDT_W-1:0] cnt;
      logic [QDT_W-1:0] load;
      logic [QDT_PRE_W-1:0] pre;
      logic irq;
   } qdt_tmr_t;

   qdt_tmr_t st_q, st_d;
   logic tick;

   // ==========================================================
   // Prescaler tick
   always_comb begin
      case (div_sel)
         QDT_DIV1: tick = enable;
         QDT_DIV16: tick = enable && (st_q.pre[3:0] == QDT_DIV16_MASK);
         QDT_DIV256: tick = enable && (st_q.pre == QDT_DIV256_MASK);
         default: tick = 1'b0;
      endcase
   end

   // ==========================================================
   // Counter
   always_comb begin
      st_d = st_q;
      st_d.pre = enable ? st_q.pre + QDT_PRE_ONE : QDT_PRE_RST;
      if (irq_clr) begin
         st_d.irq = 1'b0;
      end
      if (load_wr) begin
         // A write restarts the prescaler too, so the first period is whole.
         st_d.load = load_data;
         st_d.cnt = load_data;
         st_d.pre = QDT_PRE_RST;
      end else if (tick) begin
         if (st_q.cnt == QDT_ZERO) begin
            st_d.irq = 1'b1;
            st_d.cnt = periodic ? st_q.load : QDT_ALL_ONES;
         end else begin
            st_d.cnt = st_q.cnt - QDT_ONE;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign count = st_q.cnt;
   assign load_val = st_q.load;
   assign irq = st_q.irq;

   // ==========================================================
   // Checks
   property p_dec;
      @(posedge mclk) disable iff (srst)
      (!load_wr && tick && count != QDT_ZERO) |=> (count == $past(count) - QDT_ONE);
   endproperty
   a_dec: assert property (p_dec) else $error("counter did not step by one");

   property p_hold;
      @(posedge mclk) disable iff (srst)
      (!load_wr && !tick) |=> $stable(count);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved between ticks");

   property p_wrap;
      @(posedge mclk) disable iff (srst)
      (!load_wr && tick && count == QDT_ZERO && !periodic) |=> (count == QDT_ALL_ONES) && irq;
   endproperty
   a_wrap: assert property (p_wrap) else $error("free-running wrap wrong");

   property p_reload;
      @(posedge mclk) disable iff (srst)
      (!load_wr && tick && count == QDT_ZERO && periodic) |=> (count == $past(load_val));
   endproperty
   a_reload: assert property (p_reload) else $error("periodic reload wrong");

   property p_irq_set;
      @(posedge mclk) disable iff (srst)
      (!load_wr && tick && count == QDT_ZERO) |=> irq;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("no interrupt at zero");

   property p_load;
      @(posedge mclk) disable iff (srst)
      load_wr |=> (count == $past(load_data)) && (load_val == $past(load_data));
   endproperty
   a_load: assert property (p_load) else $error("load write did not restart");

   property p_irq_sticky;
      @(posedge mclk) disable iff (srst)
      (irq && !irq_clr) |=> irq;
   endproperty
   a_irq_sticky: assert property (p_irq_sticky) else $error("irq fell uncleared");

   property p_clr_cnt;
      @(posedge mclk) disable iff (srst)
      (irq_clr && !load_wr && !tick) |=> $stable(count) && !irq;
   endproperty
   a_clr_cnt: assert property (p_clr_cnt) else $error("clear disturbed counter");

   property p_div16;
      @(posedge mclk) disable iff (srst)
      (div_sel == QDT_DIV16 && tick) |-> (st_q.pre[3:0] == QDT_DIV16_MASK);
   endproperty
   a_div16: assert property (p_div16) else $error("divide-by-16 tick misplaced");

   property p_div1;
      @(posedge mclk) disable iff (srst)
      (enable && !load_wr && div_sel == QDT_DIV1 && count != QDT_ZERO)
         |=> (count == $past(count) - QDT_ONE);
   endproperty
   a_div1: assert property (p_div1) else $error("undivided clock did not step");

   // The prescaler low nibble can only come round to its top value once in sixteen cycles.
   property p_div16_gap;
      @(posedge mclk) disable iff (srst)
      (tick && div_sel == QDT_DIV16)
         |=> (!tick || div_sel != QDT_DIV16) [*8] ##1 (!tick || div_sel != QDT_DIV16) [*7];
   endproperty
   a_div16_gap: assert property (p_div16_gap) else $error("ticks too close");

   property p_div16_period;
      @(posedge mclk) disable iff (srst)
      (tick && !load_wr && div_sel == QDT_DIV16) ##1 (enable && !load_wr) [*8]
         ##1 (enable && !load_wr) [*7] |=> (tick || !enable || div_sel != QDT_DIV16);
   endproperty
   a_div16_period: assert property (p_div16_period) else $error("tick missed");

   property p_div256_gap;
      @(posedge mclk) disable iff (srst)
      (tick && div_sel == QDT_DIV256)
         |=> (!tick || div_sel != QDT_DIV256) [*8] ##1 (!tick || div_sel != QDT_DIV256) [*8];
   endproperty
   a_div256_gap: assert property (p_div256_gap) else $error("ticks too close");

   property p_idle;
      @(posedge mclk) disable iff (srst)
      (!enable && !load_wr) |=> $stable(count);
   endproperty
   a_idle: assert property (p_idle) else $error("counter moved while stopped");

   property p_irq_cause;
      @(posedge mclk) disable iff (srst)
      (!irq && (load_wr || !tick || count != QDT_ZERO)) |=> !irq;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without zero");

   property p_load_keep;
      @(posedge mclk) disable iff (srst)
      !load_wr |=> $stable(load_val);
   endproperty
   a_load_keep: assert property (p_load_keep) else $error("load value lost");

   property p_clr;
      @(posedge mclk) disable iff (srst)
      (irq_clr && (load_wr || !tick || count != QDT_ZERO)) |=> !irq;
   endproperty
   a_clr: assert property (p_clr) else $error("clear did not drop interrupt");
endmodule // qdt_timer

// ### rtl/qdt_top.sv
// Four independent down-counting timers with plain control and status ports.
module qdt_top
   import qdt_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Per-timer control
   input wire logic [qdt_pkg::QDT_NUM-1:0] enable,
   input wire logic [qdt_pkg::QDT_NUM-1:0] periodic,
   input wire qdt_pkg::qdt_div_t div_sel [qdt_pkg::QDT_NUM],
   input wire logic [qdt_pkg::QDT_NUM-1:0] load_wr,
   input wire logic [qdt_pkg::QDT_W-1:0] load_data [qdt_pkg::QDT_NUM],
   input wire logic [qdt_pkg::QDT_NUM-1:0] irq_clr,
   // Per-timer status
   output logic [qdt_pkg::QDT_W-1:0] count [qdt_pkg::QDT_NUM],
   output logic [qdt_pkg::QDT_W-1:0] load_val [qdt_pkg::QDT_NUM],
   output logic [qdt_pkg::QDT_NUM-1:0] irq
);
   // ==========================================================
   // Channels share nothing but the clock and the reset, so they cannot disturb each other.
   for (genvar i = 0; i < QDT_NUM; i++) begin : g_tmr
      qdt_timer u_tmr (
         .mclk(mclk),
         .srst(srst),
         .enable(enable[i]),
         .periodic(periodic[i]),
         .div_sel(div_sel[i]),
         .load_wr(load_wr[i]),
         .load_data(load_data[i]),
         .irq_clr(irq_clr[i]),
         .count(count[i]),
         .load_val(load_val[i]),
         .irq(irq[i])
      );
   end
endmodule // qdt_top

// ### verif/qdt_tb_top.sv
// Self-checking bench for the quad down-counter timer block.
module qdt_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import qdt_pkg::*;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [QDT_NUM-1:0] enable = '0;
   logic [QDT_NUM-1:0] periodic = '0;
   logic [QDT_NUM-1:0] load_wr = '0;
   logic [QDT_NUM-1:0] irq_clr = '0;
   qdt_div_t div_sel [QDT_NUM] = '{default: QDT_DIV1};
   logic [QDT_W-1:0] load_data [QDT_NUM] = '{default: '0};
   logic [QDT_W-1:0] count [QDT_NUM];
   logic [QDT_W-1:0] load_val [QDT_NUM];
   logic [QDT_NUM-1:0] irq;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   qdt_top dut_u (.mclk(mclk), .srst(srst), .enable(enable), .periodic(periodic),
      .div_sel(div_sel), .load_wr(load_wr), .load_data(load_data), .irq_clr(irq_clr),
      .count(count), .load_val(load_val), .irq(irq));
   always #50 mclk = ~mclk;
   // ==========================================================
   // Checking and closing
   task automatic results;
      if (n_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // A hang must still end in the verdict, so it is counted as a mismatch.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         results();
      end
   end
   task automatic chk(input logic [QDT_W-1:0] got, input logic [QDT_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Tasks start and end just after a falling edge.
   task automatic load(input int t, input logic [QDT_W-1:0] v);
      load_data[t] = v;
      load_wr[t] = 1'b1;
      @(negedge mclk);
      load_wr[t] = 1'b0;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_periodic;
      periodic[0] = 1'b1;
      enable[0] = 1'b1;
      load(0, 32'h3);
      chk(load_val[0], 32'h3);
      for (int k = 3; k >= 0; k--) begin
         chk(count[0], k);
         chk(irq[0], 1'b0);
         @(negedge mclk);
      end
      chk(count[0], 32'h3);
      chk(irq[0], 1'b1);
      @(negedge mclk);
      chk(irq[0], 1'b1);
      irq_clr[0] = 1'b1;
      @(negedge mclk);
      irq_clr[0] = 1'b0;
      chk(irq[0], 1'b0);
      chk(count[0], 32'h1);
      @(negedge mclk);
      irq_clr[0] = 1'b1;
      @(negedge mclk);
      irq_clr[0] = 1'b0;
      chk(count[0], 32'h3);
      chk(irq[0], 1'b1);
      enable[0] = 1'b0;
   endtask
   task automatic t_freerun;
      enable[1] = 1'b1;
      load(1, 32'h1);
      chk(count[1], 32'h1);
      @(negedge mclk);
      chk(count[1], 32'h0);
      @(negedge mclk);
      chk(count[1], QDT_ALL_ONES);
      chk(irq[1], 1'b1);
      @(negedge mclk);
      chk(count[1], 32'hfffffffe);
      load(1, 32'h10);
      chk(count[1], 32'h10);
      chk(load_val[1], 32'h10);
      @(negedge mclk);
      chk(count[1], 32'hf);
      enable[1] = 1'b0;
   endtask
   task automatic t_div(input int t, input qdt_div_t sel, input int n);
      div_sel[t] = sel;
      enable[t] = 1'b1;
      load(t, 32'h5);
      repeat (n - 1) @(negedge mclk);
      chk(count[t], 32'h5);
      @(negedge mclk);
      chk(count[t], 32'h4);
      repeat (n - 1) @(negedge mclk);
      chk(count[t], 32'h4);
      @(negedge mclk);
      chk(count[t], 32'h3);
      enable[t] = 1'b0;
   endtask
   task automatic t_reset;
      div_sel[3] = QDT_DIV1;
      enable[3] = 1'b1;
      srst = 1'b1;
      @(negedge mclk);
      srst = 1'b0;
      chk(count[3], 32'h0);
      chk(load_val[3], 32'h0);
      chk(irq, 4'h0);
      @(negedge mclk);
      chk(count[3], QDT_ALL_ONES);
      chk(irq, 4'h8);
      enable[3] = 1'b0;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (6) @(negedge mclk);
      srst = 1'b0;
      chk(count[2], 32'h0);
      chk(irq, 4'h0);
      t_periodic();
      t_freerun();
      t_div(2, QDT_DIV16, 16);
      chk(count[3], 32'h0);
      t_div(3, QDT_DIV256, 256);
      chk(count[2], 32'h3);
      t_reset();
      results();
   end
endmodule // qdt_tb_top
